// >>> hw/scbr_defines.svh
`ifndef SCBR_DEFINES_SVH
`define SCBR_DEFINES_SVH
// How it works
// R1: Count on serial clock when selected, enabled.
// R2: Enable low clears counters, floats data.
// R3: Data driver on only when enabled, selected.
// R4: Deselect stops counters and enters standby.
// R5: Chip select ignored in programming mode.
// R6: Partition enable splits space into four pages.
// R7: Partition select picks quarter, read from start.
// R8: Partitioning off streams the whole range.
// R9: Partition inputs ignored in programming mode.
// R10: Cascade output low at page end.
// R11: Cascade stays low, follows select, clears.
// R12: Float data after last bit, cascade low.
// R13: Power-up clears the address counter.
// R14: Ready pulled low during power-on reset.
// R15: Mode select low enters programming mode.
// R16: Device select gates programming access.
// R17: Programming: clock input, data open collector.
// R18: Reading: data pin is three-state output.
// R19: Sixteen million single bits read serially.
// R20: Host keeps partition enable low unpaged.
// R21: Host sets enable and select for paging.
// R22: Downstream device drives when select falls.
// R23: Standby keeps data floating despite enable.
// R24: Bit counter wraps into address counter.
// R25: Data shows stored bit at new position.

// Word address width and bits per word: 2^20 x 16 bits.
`define SCBR_ADDR_W 20
`define SCBR_BIT_W 4
`define SCBR_PAGE_W 2
`define SCBR_OFF_RST 20'h00000
`define SCBR_BIT_RST 4'h0
`define SCBR_BIT_LAST 4'hf
`define SCBR_FULL_LAST 20'hfffff
`define SCBR_PAGE_LAST 20'h3ffff

// Power-on reset hold time and its length in clock cycles.
`define SCBR_CLK_MHZ 200
`define SCBR_POR_NS 1000
`define SCBR_POR_CYC ((`SCBR_POR_NS * `SCBR_CLK_MHZ) / 1000)
`define SCBR_POR_W 8
`endif

// >>> hw/scbr_pkg.sv
`include "scbr_defines.svh"
package scbr_pkg;

	// Read position inside the selected space.
	typedef struct packed {
		logic [`SCBR_ADDR_W-1:0] off;
		logic [`SCBR_BIT_W-1:0] bitn;
	} scbr_pos_s;

	// Three-state pad drive as level plus enable.
	typedef struct packed {
		logic out;
		logic oe;
	} scbr_pad_s;

	// Streaming state, Gray coded along run, last, done.
	typedef enum logic [1:0] {
		SCBR_RUN = 2'b00,
		SCBR_LAST = 2'b01,
		SCBR_DONE = 2'b11
	} scbr_link_e;

endpackage

// >>> hw/scbr_reader.sv
`timescale 1ns/1ps
`include "scbr_defines.svh"
module scbr_reader #(
	parameter int ADDR_W = `SCBR_ADDR_W,
	parameter int BIT_W = `SCBR_BIT_W
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic serial_clock,
	input wire logic chip_select_n,
	input wire logic reset_oe,
	input wire logic program_mode_n,
	input wire logic program_device_select,
	input wire logic partition_enable,
	input wire logic [1:0] partition_select,
	input wire logic data_in,
	output scbr_pkg::scbr_pad_s data_pad,
	output logic cascade_out_n,
	output logic ready_out,
	output logic ready_oe,
	output logic standby,
	input wire logic prog_wr_valid,
	output logic prog_wr_ready,
	input wire logic [ADDR_W-1:0] prog_wr_addr,
	input wire logic [(1<<BIT_W)-1:0] prog_wr_word,
	input wire logic prog_pull_low,
	output logic prog_data_seen
);
	import scbr_pkg::*;

	// Storage: one word per address, one bit streamed per step.
	logic [(1<<BIT_W)-1:0] mem [0:(1<<ADDR_W)-1]; // R19

	// System clock side: pin levels after their two-stage synchronisers, power-on count and sampled programming data.
	logic data_c;
	logic prog_c;
	logic sel_c;
	logic cs_c;
	logic [2:0] part_c;
	logic [`SCBR_POR_W-1:0] por_cnt;
	logic [`SCBR_POR_W-1:0] next_por_cnt;
	logic por_done;
	logic next_por_done;
	logic prog_seen;
	logic next_prog_seen;

	// Link side state.
	logic [ADDR_W-1:0] off_w;
	logic link_prog;
	logic link_rst_n;
	scbr_pos_s pos;
	scbr_pos_s next_pos;
	scbr_link_e state;
	scbr_link_e next_state;
	logic advance;
	logic [ADDR_W-1:0] page_last;
	logic [ADDR_W-1:0] rd_addr;
	logic rd_bit;

	// Data pin level; resets to the released, pulled-up level.
	scbr_sync #(
		.W(1),
		.RST(1'b1)
	) i_sync_data (
		.clk(clk),
		.nrst(nrst),
		.d(data_in),
		.q(data_c)
	);

	// Programming mode; resets to reading so no false entry follows.
	scbr_sync #(
		.W(1),
		.RST(1'b0)
	) i_sync_prog (
		.clk(clk),
		.nrst(nrst),
		.d(~program_mode_n),
		.q(prog_c)
	); // R15

	// Device select for programming access.
	scbr_sync #(
		.W(1),
		.RST(1'b0)
	) i_sync_sel (
		.clk(clk),
		.nrst(nrst),
		.d(program_device_select),
		.q(sel_c)
	);

	// Chip select seen from the system clock; resets deselected.
	scbr_sync #(
		.W(1),
		.RST(1'b1)
	) i_sync_cs (
		.clk(clk),
		.nrst(nrst),
		.d(chip_select_n),
		.q(cs_c)
	);

	// Partition inputs; they are quasi-static once a frame has begun.
	scbr_sync #(
		.W(3),
		.RST(3'h0)
	) i_sync_part (
		.clk(clk),
		.nrst(nrst),
		.d({partition_enable, partition_select}),
		.q(part_c)
	);

	// Power-on counter holds ready low until it expires.
	always_comb begin
		next_por_cnt = por_cnt;
		next_por_done = por_done;
		if (!por_done) begin
			if (por_cnt == `SCBR_POR_W'(`SCBR_POR_CYC - 1)) begin
				next_por_done = 1'b1;
			end else begin
				next_por_cnt = por_cnt + `SCBR_POR_W'(1);
			end
		end
		next_prog_seen = data_c;
	end

	// Register the power-on state and sampled programming data.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			por_cnt <= '0;
			por_done <= 1'b0;
			prog_seen <= 1'b1;
		end else begin
			por_cnt <= next_por_cnt;
			por_done <= next_por_done;
			prog_seen <= next_prog_seen;
		end
	end

	// Ready is open collector: driven low only until power-up ends.
	assign ready_out = 1'b0;
	assign ready_oe = ~por_done; // R14

	// Standby whenever reading mode and deselected.
	assign standby = ~prog_c & cs_c; // R4

	// Programming access only with device select high.
	assign prog_wr_ready = prog_c & sel_c & por_done; // R16 R5
	assign prog_data_seen = prog_seen;

	// Programming writes land in the storage array.
	always_ff @(posedge clk) begin
		if (prog_wr_valid && prog_wr_ready) begin
			mem[prog_wr_addr] <= prog_wr_word;
		end
	end

	// Mode level crossed into the link domain; it needs two link edges.
	scbr_sync #(
		.W(1),
		.RST(1'b0)
	) i_sync_link_prog (
		.clk(serial_clock),
		.nrst(nrst),
		.d(~program_mode_n),
		.q(link_prog)
	);

	// Offset cut to the storage width actually built.
	assign off_w = pos.off[ADDR_W-1:0];

	// Counters clear on power-up or enable low, regardless of select.
	assign link_rst_n = nrst & reset_oe; // R2 R13

	// Page end and physical address from partition inputs.
	always_comb begin
		if (part_c[2]) begin
			// A page is a quarter of the storage, so its end follows the width.
			page_last = {`SCBR_PAGE_W'(0),
				{(ADDR_W-`SCBR_PAGE_W){1'b1}}}; // R6
			rd_addr = {part_c[1:0],
				off_w[ADDR_W-`SCBR_PAGE_W-1:0]}; // R7
		end else begin
			page_last = '1; // R8
			rd_addr = off_w;
		end
	end

	// Count only when reading, selected, enabled and not finished.
	assign advance = ~link_prog & ~chip_select_n & reset_oe
		& (state != SCBR_DONE); // R1 R4 R9

	// Next read position and streaming state.
	always_comb begin
		next_pos = pos;
		next_state = state;
		if (advance) begin
			if (pos.bitn == BIT_W'(`SCBR_BIT_LAST)) begin
				next_pos.bitn = BIT_W'(`SCBR_BIT_RST); // R24
				if (off_w == page_last) begin
					next_state = SCBR_DONE; // R10
				end else begin
					next_pos.off = `SCBR_ADDR_W'(off_w + ADDR_W'(1));
					if (off_w + ADDR_W'(1) == page_last) begin
						next_state = SCBR_LAST;
					end else begin
						next_state = SCBR_RUN;
					end
				end
			end else begin
				next_pos.bitn = pos.bitn + BIT_W'(1);
			end
		end
	end

	// Link registers, cleared to the start of the selected space.
	always_ff @(posedge serial_clock or negedge link_rst_n) begin
		if (!link_rst_n) begin
			pos.off <= `SCBR_OFF_RST;
			pos.bitn <= `SCBR_BIT_RST;
			state <= SCBR_RUN;
		end else begin
			pos <= next_pos;
			state <= next_state;
		end
	end

	// Stored bit at the current position.
	assign rd_bit = mem[rd_addr][pos.bitn]; // R25

	// Data pad: stream output when reading, open collector when
	// programming.
	always_comb begin
		if (prog_c) begin
			data_pad.out = 1'b0; // R17
			data_pad.oe = sel_c & prog_pull_low;
		end else begin
			data_pad.out = rd_bit; // R18
			data_pad.oe = ~link_prog & reset_oe & ~chip_select_n
				& (state != SCBR_DONE); // R3 R12 R23 R22
		end
	end

	// Cascade low once done while selected, then follows select.
	assign cascade_out_n = ~(~link_prog & (state == SCBR_DONE)
		& ~chip_select_n); // R10 R11

endmodule

// Two-stage synchroniser; nothing but the second stage is read outside.
module scbr_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	import scbr_pkg::*;

	logic [W-1:0] meta;
	logic [W-1:0] next_meta;
	logic [W-1:0] next_q;

	// The first stage takes the pin, the second takes the first.
	always_comb begin
		next_meta = d;
		next_q = meta;
	end

	// Both stages reset to the idle level of the pin they follow.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			meta <= RST;
			q <= RST;
		end else begin
			meta <= next_meta;
			q <= next_q;
		end
	end

endmodule

// >>> tb/scbr_fpga_model.sv
`timescale 1ns/1ps
module scbr_fpga_model (
	output logic serial_clock,
	output logic chip_select_n,
	output logic reset_oe,
	input wire logic data_in
);
	logic got [$];
	// The loader idles deselected with the counters held clear.
	initial begin
		serial_clock = 1'b0;
		chip_select_n = 1'b1;
		reset_oe = 1'b0;
	end
	// Sets select and enable between frames.
	task automatic ctl(input logic cs, input logic oe);
		chip_select_n = cs;
		reset_oe = oe;
	endtask
	// Takes the wire level before each rising edge, then clocks once.
	task automatic pull(input int n);
		repeat (n) begin
			#3 got.push_back(data_in);
			serial_clock = 1'b1;
			#3 serial_clock = 1'b0;
		end
	endtask
endmodule

// >>> tb/scbr_reader_assertions.sv
`timescale 1ns/1ps
module scbr_reader_chk (
	input wire logic clk,
	input wire logic nrst,
	input wire logic chip_select_n,
	input wire logic reset_oe,
	input wire logic program_mode_n,
	input wire logic prog_pull_low,
	input scbr_pkg::scbr_pad_s data_pad,
	input wire logic cascade_out_n,
	input wire logic ready_out,
	input wire logic ready_oe,
	input wire logic standby
);
	import scbr_pkg::*;
	logic [7:0] por;
	logic [7:0] next_por;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// Counts edges since reset release, saturating past the hold time.
	always_comb next_por = (por == 8'hc9) ? por : por + 8'h01;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			por <= 8'h00;
		else
			por <= next_por;
	end
	a_ready_held: assert property (por < 8'hc7 |-> ready_oe)
		else $error("ready released early");
	a_ready_gone: assert property (por == 8'hc9 |-> !ready_oe && !ready_out)
		else $error("ready still held");
	a_data_float: assert property (!prog_pull_low && (!reset_oe ||
		chip_select_n) |-> !data_pad.oe) else $error("data driven");
	a_data_drive: assert property (program_mode_n && reset_oe &&
		!chip_select_n && cascade_out_n |-> data_pad.oe)
		else $error("data not driven");
	a_casc_sel: assert property (!cascade_out_n |-> !chip_select_n && reset_oe)
		else $error("cascade low unselected");
	a_casc_float: assert property (!cascade_out_n |-> !data_pad.oe)
		else $error("data driven after end");
	a_standby_on: assert property ((chip_select_n && program_mode_n) [*6]
		|-> standby) else $error("no standby");
	a_standby_off: assert property (!chip_select_n [*6] |-> !standby)
		else $error("standby while selected");
endmodule
bind scbr_reader scbr_reader_chk i_chk (.clk, .nrst, .chip_select_n,
	.reset_oe, .program_mode_n, .prog_pull_low, .data_pad, .cascade_out_n,
	.ready_out, .ready_oe, .standby);

// >>> tb/testbench.sv
`timescale 1ns/1ps
module testbench;
	import scbr_pkg::*;
	logic clk, nrst, program_mode_n, program_device_select, partition_enable;
	logic prog_wr_valid, prog_wr_ready, prog_data_seen, prog_pull_low;
	logic [1:0] partition_select;
	logic [3:0] prog_wr_addr;
	logic [15:0] prog_wr_word;
	logic serial_clock, chip_select_n, reset_oe, data_in;
	logic cascade_out_n, ready_out, ready_oe, standby;
	scbr_pad_s data_pad;
	int n_fail, checked;
	// Released data line rests high through its pull-up.
	assign data_in = data_pad.oe ? data_pad.out : 1'b1;
	scbr_reader #(.ADDR_W(4)) i_scbr_reader (.clk, .nrst, .serial_clock,
		.chip_select_n, .reset_oe, .program_mode_n, .program_device_select,
		.partition_enable, .partition_select, .data_in, .data_pad,
		.cascade_out_n, .ready_out, .ready_oe, .standby, .prog_wr_valid,
		.prog_wr_ready, .prog_wr_addr, .prog_wr_word, .prog_pull_low,
		.prog_data_seen);
	scbr_fpga_model i_fpga (.serial_clock, .chip_select_n, .reset_oe,
		.data_in);
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	function automatic logic [15:0] pat(input logic [3:0] a);
		return {a, ~a, a ^ 4'h5, 4'hc};
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Holds a word write until ready is seen at a rising edge.
	task automatic wr(input logic [3:0] a);
		@(negedge clk);
		prog_wr_valid = 1'b1;
		prog_wr_addr = a;
		prog_wr_word = pat(a);
		do @(posedge clk); while (prog_wr_ready !== 1'b1);
		@(negedge clk) prog_wr_valid = 1'b0;
	endtask
	// Streams one page or the whole space and checks every bit and the end.
	task automatic run(input logic pe, input logic [1:0] ps, input int n);
		logic [15:0] w;
		@(negedge clk);
		partition_enable = pe;
		partition_select = ps;
		i_fpga.ctl(1'b1, 1'b0);
		#20 i_fpga.ctl(1'b0, 1'b1);
		i_fpga.got.delete();
		i_fpga.pull(n - 1);
		#10 chk({15'h0, cascade_out_n}, 16'h1);
		chk({15'h0, data_pad.oe}, 16'h1);
		chk({15'h0, standby}, 16'h0);
		i_fpga.pull(1);
		#10 chk({15'h0, cascade_out_n}, 16'h0);
		chk({15'h0, data_pad.oe}, 16'h0);
		for (int k = 0; k < n; k++) begin
			w = pat((pe ? {ps, 2'b00} : 4'h0) + 4'(k / 16));
			chk({15'h0, i_fpga.got[k]}, {15'h0, w[k % 16]});
		end
		i_fpga.ctl(1'b1, 1'b1);
		#10 chk({15'h0, cascade_out_n}, 16'h1);
		chk({15'h0, data_pad.oe}, 16'h0);
		$display("test pe %0d ps %0d ended", pe, ps);
	endtask
	task automatic results();
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		{nrst, program_device_select, partition_enable, prog_pull_low} = 4'h0;
		{prog_wr_valid, prog_wr_addr, prog_wr_word, partition_select} = 23'h0;
		program_mode_n = 1'b1;
		repeat (3) @(negedge clk);
		nrst = 1'b1;
		@(negedge clk) chk({15'h0, ready_oe}, 16'h1);
		repeat (205) @(negedge clk);
		chk({15'h0, ready_oe}, 16'h0);
		program_mode_n = 1'b0;
		program_device_select = 1'b1;
		repeat (4) @(negedge clk);
		prog_pull_low = 1'b1;
		repeat (4) @(negedge clk);
		chk({15'h0, prog_data_seen}, 16'h0);
		prog_pull_low = 1'b0;
		for (int a = 0; a < 16; a++) wr(4'(a));
		program_mode_n = 1'b1;
		repeat (4) @(negedge clk);
		i_fpga.pull(3);
		chk({15'h0, standby}, 16'h1);
		for (int p = 0; p < 4; p++) run(1'b1, 2'(p), 64);
		run(1'b0, 2'h3, 256);
		results();
	end
	initial begin
		#20000 n_fail++;
		results();
	end
endmodule
